// ==== rc_pkg.sv ====
package rc_pkg;

  // register byte offsets
  localparam logic [7:0] RC_OFS_CTRL     = 8'h00;
  localparam logic [7:0] RC_OFS_OI1      = 8'h04;
  localparam logic [7:0] RC_OFS_OI4      = 8'h10;
  localparam logic [7:0] RC_OFS_RSD      = 8'h14;
  localparam logic [7:0] RC_OFS_RSLD     = 8'h18;
  localparam logic [7:0] RC_OFS_STATUS   = 8'h1c;
  localparam logic [7:0] RC_OFS_INT_STAT = 8'h20;
  localparam logic [7:0] RC_OFS_INT_MASK = 8'h24;

  // timer widths and reset values (counts of processing clocks)
  localparam int              RC_TW       = 24;
  localparam logic [RC_TW-1:0] RC_OI_RST   = 24'h000000;
  localparam logic [RC_TW-1:0] RC_RSD_RST  = 24'h000000;
  localparam logic [RC_TW-1:0] RC_RSLD_RST = 24'h000000;

  // control register
  localparam int         RC_CTRL_EN_BIT = 0;
  localparam logic [0:0] RC_CTRL_RST    = 1'h1;

  // event bits, shared by int status and int mask
  localparam int         RC_EV_W       = 4;
  localparam int         RC_EV_INIT    = 0;
  localparam int         RC_EV_LOCKOUT = 1;
  localparam int         RC_EV_CLOSE   = 2;
  localparam int         RC_EV_RESET   = 3;
  localparam logic [3:0] RC_EV_RST     = 4'h0;

  // status register fields
  localparam int RC_SF_SHOT_LSB = 0;
  localparam int RC_SF_LAST_LSB = 4;
  localparam int RC_SF_CY_BIT   = 8;
  localparam int RC_SF_LO_BIT   = 9;
  localparam int RC_SF_CLS_BIT  = 10;
  localparam int RC_SF_OPT_BIT  = 11;
  localparam int RC_SF_RST_BIT  = 12;

  localparam logic [2:0] RC_SHOT_MAX = 3'h4;

  typedef enum logic [2:0] {
    RC_ST_RESET   = 3'b001,
    RC_ST_CYCLE   = 3'b010,
    RC_ST_LOCKOUT = 3'b100
  } rc_state_e;

  typedef struct packed {
    logic reclose_initiate_cond;
    logic reclose_initiate_supervise;
    logic breaker_closed_status;
    logic close_unlatch_cond;
  } rc_line_s;

endpackage

// ==== rc_interval_timer.sv ====
module rc_interval_timer
  import rc_pkg::*;
#(
  parameter int W = 24
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // control
  input  wire logic         start,
  input  wire logic         abort,
  input  wire logic [W-1:0] load,
  // state
  output logic              busy_q,
  output logic              done_q,
  output logic [W-1:0]      count_q
);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      count_q <= '0;
    end else begin
      done_q <= 1'b0;
      if (abort) begin
        busy_q <= 1'b0;
      end else if (start) begin
        count_q <= load;
        busy_q  <= 1'b1;
      end else if (busy_q) begin
        if (count_q <= {{(W-1){1'b0}}, 1'b1}) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// ==== rc_shot_counter_top.sv ====
// Function
// - shot stays zero during first open interval; each interval expiry adds one
// - shot never advances past the computed last-shot value
// - shot clears to zero whenever the sequencer re-enters reset
// - five one-hot shot flags, only the current shot's flag high
// - initiate acts only on its zero-to-one transition
// - rising initiate starts open-interval timing only if supervision is high then
// - rising initiate with supervision low sends the sequencer straight to lockout
// - reclose-cycle flag low at first trip, high during later trips
// - with unlatch condition low, close stays on until breaker reports closed
// - zero interval disables it and all after; last shot counts leading nonzero ones
// - open intervals run one after another, each after the previous reclose fails
module rc_shot_counter_top
  import rc_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // breaker and trip logic conditions
  input  wire rc_line_s    line_in,
  // shot indication
  output logic             shot_zero_flag,
  output logic             shot_one_flag,
  output logic             shot_two_flag,
  output logic             shot_three_flag,
  output logic             shot_four_flag,
  // sequencer outputs
  output logic             close_cmd,
  output logic             reclose_cycle_flag,
  output logic             lockout_flag,
  output logic             open_timing_flag,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  logic [0:0]         ctrl_q;
  logic [RC_TW-1:0]   oi_q [4];
  logic [RC_TW-1:0]   rsd_q;
  logic [RC_TW-1:0]   rsld_q;
  logic [RC_EV_W-1:0] int_stat_q;
  logic [RC_EV_W-1:0] int_mask_q;
  logic [RC_EV_W-1:0] int_stat_d;
  logic               irq_q;
  logic               wr_pend_q;
  logic [7:0]         wr_addr_q;
  logic [31:0]        hrdata_q;
  logic               hreadyout_q;
  logic               hresp_q;
  rc_state_e          state_q;
  rc_state_e          state_d;
  logic [2:0]         shot_q;
  logic [2:0]         shot_d;
  logic [4:0]         shot_hot_q;
  logic               close_q;
  logic               close_d;
  logic               cy_q;
  logic               lo_q;
  logic               init_prev_q;

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire        ahb_go   = hsel & htrans[1] & hready;
  wire [7:0]  ra       = haddr[7:0];
  wire        wr_ctrl  = wr_pend_q & (wr_addr_q == RC_OFS_CTRL);
  wire        wr_oi    = wr_pend_q & (wr_addr_q >= RC_OFS_OI1) & (wr_addr_q <= RC_OFS_OI4);
  wire [7:0]  wr_oi_of = wr_addr_q - RC_OFS_OI1;
  wire [1:0]  wr_oi_ix = wr_oi_of[3:2];
  wire        wr_rsd   = wr_pend_q & (wr_addr_q == RC_OFS_RSD);
  wire        wr_rsld  = wr_pend_q & (wr_addr_q == RC_OFS_RSLD);
  wire        wr_istat = wr_pend_q & (wr_addr_q == RC_OFS_INT_STAT);
  wire        wr_imask = wr_pend_q & (wr_addr_q == RC_OFS_INT_MASK);
  wire        rd_oi    = (ra >= RC_OFS_OI1) & (ra <= RC_OFS_OI4);
  wire [7:0]  rd_oi_of = ra - RC_OFS_OI1;
  wire [1:0]  rd_oi_ix = rd_oi_of[3:2];

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer decode

  wire        brk      = line_in.breaker_closed_status;
  wire        sup      = line_in.reclose_initiate_supervise;
  wire        enabled  = ctrl_q[RC_CTRL_EN_BIT];
  wire        init_rise = line_in.reclose_initiate_cond & ~init_prev_q;
  wire        in_reset = (state_q == RC_ST_RESET);
  wire        in_cycle = (state_q == RC_ST_CYCLE);
  wire        in_lo    = (state_q == RC_ST_LOCKOUT);

  // last shot: nonzero intervals ahead of the first zero one
  wire [2:0]  last_shot = (oi_q[0] == '0) ? 3'h0 :
                          (oi_q[1] == '0) ? 3'h1 :
                          (oi_q[2] == '0) ? 3'h2 :
                          (oi_q[3] == '0) ? 3'h3 : RC_SHOT_MAX;

  logic             oi_busy;
  logic             oi_done;
  logic [RC_TW-1:0] oi_cnt;
  logic             rs_busy;
  logic             rs_done;
  logic [RC_TW-1:0] rs_cnt;

  // a trip during timing is not a fresh initiation; only a failed reclose is
  wire        shots_left = in_cycle ? (shot_q < last_shot) : (last_shot != 3'h0);
  wire        accept   = init_rise & sup & enabled & ~in_lo & ~oi_busy & shots_left;
  wire        refuse_lo = init_rise & enabled & ~in_lo &
                          (~sup | (in_cycle & ~oi_busy & ~shots_left));
  wire [1:0]  oi_sel   = shot_q[1:0];
  wire        rs_start = ~in_reset & brk & ~oi_busy & ~rs_busy & ~rs_done &
                         ~init_rise;
  wire        rs_abort = ~brk | init_rise;
  wire [RC_TW-1:0] rs_load = in_lo ? rsld_q : rsd_q;

  wire [RC_EV_W-1:0] events = {rs_done, oi_done, refuse_lo, accept};

  ////////////////////////////////////////////////////////////////////////////////
  // timers

  rc_interval_timer #(.W(RC_TW)) u_open_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (accept),
    .abort   (refuse_lo),
    .load    (oi_q[oi_sel]),
    .busy_q  (oi_busy),
    .done_q  (oi_done),
    .count_q (oi_cnt)
  );

  rc_interval_timer #(.W(RC_TW)) u_reset_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (rs_start),
    .abort   (rs_abort),
    .load    (rs_load),
    .busy_q  (rs_busy),
    .done_q  (rs_done),
    .count_q (rs_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_d = state_q;
    if (refuse_lo) begin
      state_d = RC_ST_LOCKOUT;
    end else if (accept) begin
      state_d = RC_ST_CYCLE;
    end else if (rs_done) begin
      state_d = RC_ST_RESET;
    end
  end

  always_comb begin
    case (state_d)
      RC_ST_RESET: begin
        shot_d = 3'h0;
      end
      RC_ST_CYCLE, RC_ST_LOCKOUT: begin
        if (oi_done && (shot_q < last_shot)) begin
          shot_d = shot_q + 3'h1;
        end else begin
          shot_d = shot_q;
        end
      end
      default: begin
        shot_d = 3'h0;
      end
    endcase
  end

  // close latched until breaker closed unless unlatch condition is up
  assign close_d = oi_done | (close_q & ~brk & ~line_in.close_unlatch_cond);

  assign int_stat_d = (int_stat_q & ~({RC_EV_W{wr_istat}} & hwdata[RC_EV_W-1:0])) | events;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer flops

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q     <= RC_ST_RESET;
      shot_q      <= 3'h0;
      shot_hot_q  <= 5'h01;
      close_q     <= 1'b0;
      cy_q        <= 1'b0;
      lo_q        <= 1'b0;
      init_prev_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      shot_q      <= shot_d;
      shot_hot_q  <= 5'(5'h01 << shot_d);
      close_q     <= close_d;
      cy_q        <= (state_d == RC_ST_CYCLE);
      lo_q        <= (state_d == RC_ST_LOCKOUT);
      init_prev_q <= line_in.reclose_initiate_cond;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register flops

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q     <= RC_CTRL_RST;
      rsd_q      <= RC_RSD_RST;
      rsld_q     <= RC_RSLD_RST;
      int_stat_q <= RC_EV_RST;
      int_mask_q <= RC_EV_RST;
      irq_q      <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        oi_q[i] <= RC_OI_RST;
      end
    end else begin
      if (wr_ctrl) ctrl_q <= hwdata[0:0];
      if (wr_oi) oi_q[wr_oi_ix] <= hwdata[RC_TW-1:0];
      if (wr_rsd) rsd_q <= hwdata[RC_TW-1:0];
      if (wr_rsld) rsld_q <= hwdata[RC_TW-1:0];
      if (wr_imask) int_mask_q <= hwdata[RC_EV_W-1:0];
      int_stat_q <= int_stat_d;
      irq_q      <= |(int_stat_d & int_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave

  wire [31:0] status_word = (32'h0000_0000
                            | (32'(shot_q) << RC_SF_SHOT_LSB)
                            | (32'(last_shot) << RC_SF_LAST_LSB)
                            | (32'(cy_q) << RC_SF_CY_BIT)
                            | (32'(lo_q) << RC_SF_LO_BIT)
                            | (32'(close_q) << RC_SF_CLS_BIT)
                            | (32'(oi_busy) << RC_SF_OPT_BIT)
                            | (32'(rs_busy) << RC_SF_RST_BIT));

  wire [31:0] rd_word = (ra == RC_OFS_CTRL)     ? 32'(ctrl_q) :
                        rd_oi                   ? 32'(oi_q[rd_oi_ix]) :
                        (ra == RC_OFS_RSD)      ? 32'(rsd_q) :
                        (ra == RC_OFS_RSLD)     ? 32'(rsld_q) :
                        (ra == RC_OFS_STATUS)   ? status_word :
                        (ra == RC_OFS_INT_STAT) ? 32'(int_stat_q) :
                        (ra == RC_OFS_INT_MASK) ? 32'(int_mask_q) : 32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 8'h00;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b0;
      hresp_q     <= 1'b0;
    end else begin
      wr_pend_q   <= ahb_go & hwrite;
      wr_addr_q   <= ra;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      if (ahb_go && !hwrite) hrdata_q <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign hreadyout          = hreadyout_q;
  assign hrdata             = hrdata_q;
  assign hresp              = hresp_q;
  assign shot_zero_flag     = shot_hot_q[0];
  assign shot_one_flag      = shot_hot_q[1];
  assign shot_two_flag      = shot_hot_q[2];
  assign shot_three_flag    = shot_hot_q[3];
  assign shot_four_flag     = shot_hot_q[4];
  assign close_cmd          = close_q;
  assign reclose_cycle_flag = cy_q;
  assign lockout_flag       = lo_q;
  assign open_timing_flag   = oi_busy;
  assign irq                = irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_shot_step: assert property (
    oi_done && (shot_q < last_shot) && !refuse_lo |=> shot_q == $past(shot_q) + 3'h1)
    else $error("shot did not advance on interval expiry");

  chk_shot_saturate: assert property (
    !in_reset && $stable(last_shot) |-> shot_q <= last_shot)
    else $error("shot beyond last shot");

  chk_shot_clear: assert property (
    rs_done |=> (shot_q == 3'h0) && shot_zero_flag)
    else $error("shot not cleared on return to reset");

  chk_shot_onehot: assert property (
    $onehot(shot_hot_q) && shot_hot_q[shot_q])
    else $error("shot flags not one-hot on current shot");

  chk_edge_only: assert property (
    accept || refuse_lo |-> line_in.reclose_initiate_cond && !$past(line_in.reclose_initiate_cond))
    else $error("initiate acted without rising edge");

  chk_start_sup: assert property (
    $rose(oi_busy) |-> $past(sup) && $past(init_rise))
    else $error("open interval started unsupervised");

  chk_lockout_sup: assert property (
    init_rise && !sup && enabled |=> lockout_flag && !open_timing_flag)
    else $error("unsupervised initiate did not lock out");

  chk_cycle_first: assert property (
    in_reset && accept |-> !reclose_cycle_flag ##1 reclose_cycle_flag)
    else $error("cycle flag wrong around first trip");

  chk_close_hold: assert property (
    close_q && !brk && !line_in.close_unlatch_cond |=> close_cmd)
    else $error("close dropped before breaker closed");

  chk_last_zero: assert property (
    oi_q[0] == '0 |-> last_shot == 3'h0 && !accept)
    else $error("defeated reclosing still initiated");

  chk_oi_serial: assert property (
    oi_done |=> !oi_busy ##1 !oi_busy)
    else $error("next interval started without new initiation");

endmodule

// ==== rc_breaker_model.sv ====
module rc_breaker_model
  import rc_pkg::*;
#(
  parameter int CLOSE_DLY = 4
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // relay outputs
  input  wire logic close_cmd,
  input  wire logic cycle_flag,
  // test controls
  input  wire logic trip_req,
  input  wire logic sup_off,
  input  wire logic man_close,
  // condition lines
  output rc_line_s  line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////////
  logic brk_q;
  int   dly_q;

  // breaker opens on trip; status reports a commanded close only after a slow delay, a manual close at once
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      brk_q <= 1'b1;
      dly_q <= 0;
    end else if (trip_req) begin
      brk_q <= 1'b0;
      dly_q <= 0;
    end else if (man_close) begin
      brk_q <= 1'b1;
    end else if (close_cmd && !brk_q) begin
      dly_q <= dly_q + 1;
      if (dly_q == CLOSE_DLY - 1) begin
        brk_q <= 1'b1;
      end
    end else begin
      dly_q <= 0;
    end
  end

  // supervision follows breaker closed or cycle state; unlatch kept low
  assign line_out = '{reclose_initiate_cond:      trip_req,
                      reclose_initiate_supervise: !sup_off && (brk_q || cycle_flag),
                      breaker_closed_status:      brk_q,
                      close_unlatch_cond:         1'b0};
endmodule

// ==== rc_shot_counter_tb_top.sv ====
module rc_shot_counter_tb_top
  import rc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////////
  logic        sys_clk, rst, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdq, lfsr_q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  rc_line_s    line_in;
  logic [4:0]  shf;
  logic        close_cmd, cyc, lo, opt, irq, trip_req, sup_off, man_close;
  int          error_cnt, cmp_count, exp_shot, last;
  int          oi[$];

  rc_shot_counter_top i_rc_shot_counter_top (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .line_in(line_in), .shot_zero_flag(shf[0]), .shot_one_flag(shf[1]),
    .shot_two_flag(shf[2]), .shot_three_flag(shf[3]), .shot_four_flag(shf[4]),
    .close_cmd(close_cmd), .reclose_cycle_flag(cyc), .lockout_flag(lo),
    .open_timing_flag(opt), .irq(irq));

  rc_breaker_model i_rc_breaker_model (.sys_clk(sys_clk), .rst(rst), .close_cmd(close_cmd),
    .cycle_flag(cyc), .trip_req(trip_req), .sup_off(sup_off), .man_close(man_close),
    .line_out(line_in));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic check_shot();
    logic [4:0] e;
    e = 5'h01 << exp_shot;
    cmp_count++;
    if (shf !== e) begin
      error_cnt++;
      $display("BAD shot_flags expected %h seen %h", e, shf);
    end
  endtask

  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rdq = hrdata;
  endtask

  task automatic reg_chk(string nm, logic [7:0] a, logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(nm, exp, rdq);
    check("hresp", 32'h0, 32'(hresp));
  endtask

  task automatic step(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic complete_run();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    complete_run();
  end

  initial begin
    {rst, trip_req} = 2'b10;
    {hsel, hwrite, sup_off, man_close} = 4'h0;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'b010};
    {error_cnt, cmp_count, exp_shot} = {32'h0, 32'h0, 32'h0};
    lfsr_q = 32'd84050;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    step(1);
    check_shot();
    reg_chk("ctrl", RC_OFS_CTRL, 32'h1);
    reg_chk("oi1", RC_OFS_OI1, 32'h0);
    reg_chk("unmapped", 8'h28, 32'h0);
    // two random intervals, a zero, then a nonzero one that must stay unused
    for (int k = 0; k < 4; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      oi.push_back(k == 2 ? 0 : 2 + int'(lfsr_q % 4));
      bus(1'b1, 8'(RC_OFS_OI1 + 4 * k), 32'(oi[k]));
    end
    last = 0;
    while (last < 4 && oi[last] != 0) last++;
    bus(1'b1, RC_OFS_RSD, 32'd60);
    bus(1'b1, RC_OFS_RSLD, 32'd6);
    reg_chk("rsd", RC_OFS_RSD, 32'd60);
    reg_chk("status", RC_OFS_STATUS, 32'(last) << 4);
    for (int s = 0; s <= last; s++) begin
      check("cycle_pre", 32'(s != 0), 32'(cyc));
      @(posedge sys_clk) trip_req <= 1'b1;
      step(1);
      if (s == last) begin
        check("lockout", 32'h1, 32'(lo));
        check_shot();
        break;
      end
      check("cycle", 32'h1, 32'(cyc));
      check("open", 32'h1, 32'(opt));
      step(oi[s] - 1);
      check("close_early", 32'h0, 32'(close_cmd));
      check_shot();
      // timer busy drops at expiry; close and shot follow one edge later
      step(1);
      check("open_end", 32'h0, 32'(opt));
      check("close_late", 32'h0, 32'(close_cmd));
      step(1);
      exp_shot++;
      check("close", 32'h1, 32'(close_cmd));
      check_shot();
      @(posedge sys_clk) trip_req <= 1'b0;
      step(2);
      check("close_hold", 32'h1, 32'(close_cmd));
      step(8);
      check("close_drop", 32'h0, 32'(close_cmd));
    end
    @(posedge sys_clk) {trip_req, man_close} <= 2'b01;
    step(12);
    exp_shot = 0;
    check("lockout_left", 32'h0, 32'(lo));
    check_shot();
    reg_chk("int_stat", RC_OFS_INT_STAT, 32'hf);
    check("irq_masked", 32'h0, 32'(irq));
    bus(1'b1, RC_OFS_INT_MASK, 32'hf);
    step(2);
    check("irq_on", 32'h1, 32'(irq));
    bus(1'b1, RC_OFS_INT_STAT, 32'hf);
    step(2);
    check("irq_off", 32'h0, 32'(irq));
    reg_chk("int_clr", RC_OFS_INT_STAT, 32'h0);
    // unsupervised rise goes straight to lockout
    @(posedge sys_clk) sup_off <= 1'b1;
    @(posedge sys_clk) trip_req <= 1'b1;
    step(1);
    check("lo_unsup", 32'h1, 32'(lo));
    check("open_unsup", 32'h0, 32'(opt));
    @(posedge sys_clk) {trip_req, sup_off} <= 2'b00;
    step(12);
    check("lo_reset", 32'h0, 32'(lo));
    // level held high and falling edge give no action; disabled block ignores rise
    bus(1'b1, RC_OFS_CTRL, 32'h0);
    @(posedge sys_clk) trip_req <= 1'b1;
    step(3);
    check("disabled", 32'h0, 32'({cyc, lo}));
    bus(1'b1, RC_OFS_CTRL, 32'h1);
    step(2);
    check("level_high", 32'h0, 32'({cyc, lo, opt}));
    @(posedge sys_clk) trip_req <= 1'b0;
    step(2);
    check("fall_edge", 32'h0, 32'({cyc, lo, opt}));
    check_shot();
    complete_run();
  end
endmodule
